// *** design/acmp2_map.svh ***
`ifndef ACMP2_MAP_SVH
`define ACMP2_MAP_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ACMP2_CTRL_IDX 12'h0AD
`define ACMP2_IRQ_STAT_IDX 12'h0C0
`define ACMP2_IRQ_CLR_IDX 12'h0C1
`define ACMP2_IRQ_EN_IDX 12'h0C2
`define ACMP2_IDX_TO_ADDR(idx) ((idx) << 2)

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ACMP2_HYS_BIT 6
`define ACMP2_EN_BIT 5
`define ACMP2_PAIR_BIT 4
`define ACMP2_NEG_BIT 3
`define ACMP2_OE_BIT 2
`define ACMP2_OUT_BIT 1
`define ACMP2_FLAG_BIT 0
`define ACMP2_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Interrupt layout and bus answers
// ----------------------------------------------------------------
`define ACMP2_IRQ_CHANGE_BIT 0
`define ACMP2_IRQ_EN_RST 1'h0
`define ACMP2_RESP_OKAY 2'h0
`define ACMP2_RESP_SLVERR 2'h2

`endif

// *** design/acmp2_pkg.sv ***
package acmp2_pkg;
    typedef logic [11:0] acmp2_addr_t;
    typedef logic [31:0] acmp2_data_t;
    typedef logic [3:0] acmp2_strb_t;
    typedef logic [1:0] acmp2_resp_t;
endpackage

// *** design/acmp2_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module acmp2_sync (
    input wire logic mclk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic asyncIn, // Level from outside the clock domain
    output logic syncOut // Level retimed to mclk
);
    logic stage1_ff;
    logic stage2_ff;

    // First stage feeds only the second, to contain metastability
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule
`default_nettype wire

// *** design/acmp2_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
module acmp2_flag (
    input wire logic mclk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic setIn, // Hardware event
    input wire logic clrIn, // Clear request
    output logic flagOut // Sticky flag
);
    logic flag_ff;

    // A set in the clearing cycle wins so no event is lost
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (setIn) begin
            flag_ff <= 1'b1;
        end else if (clrIn) begin
            flag_ff <= 1'b0;
        end
    end

    assign flagOut = flag_ff;
endmodule
`default_nettype wire

// *** design/acmp2_ctrl.sv ***
// Overview of operation
// - Bit 6 switches comparator input hysteresis on; zero means none.
// - Bit 5 enables the comparator and drives its power-up control.
// - Bit 4 picks first or second positive/negative input pin pair.
// - Bit 3 picks reference pin or internal reference as negative input.
// - Bit 2 with enable routes raw, unretimed comparator output to pin.
// - Bit 1 shows synchronised output, read-only, zero while disabled.
// - Bit 0 is set on every output change while enabled, rising or falling.
// - A change also sets interrupt status; with its enable set, it raises a request.
// - Flag cleared by software and whenever comparator is disabled.
`include "acmp2_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acmp2_ctrl (
    input wire logic mclk, // System clock, 10 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire acmp2_pkg::acmp2_addr_t awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire acmp2_pkg::acmp2_data_t wdata, // Write data
    input wire acmp2_pkg::acmp2_strb_t wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output acmp2_pkg::acmp2_resp_t bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire acmp2_pkg::acmp2_addr_t araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output acmp2_pkg::acmp2_data_t rdata, // Read data
    output acmp2_pkg::acmp2_resp_t rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic cmpRaw, // Raw comparator output, asynchronous
    output logic hysteresisEn, // Hysteresis on at comparator inputs
    output logic comparatorEn, // Comparator power-up control
    output logic inputPairSel, // 0 first pin pair, 1 second pin pair
    output logic negativeInputSel, // 0 reference pin, 1 internal reference
    output logic cmpPinOut, // Comparator output pin data
    output logic cmpPinOe, // Comparator output pin enable
    output logic irq // Interrupt request, level
);
    import acmp2_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave: write channels
    // ----------------------------------------------------------------
    logic awReady_ff;
    logic awHeld_ff;
    acmp2_addr_t awAddr_ff;
    logic wReady_ff;
    logic wHeld_ff;
    acmp2_data_t wData_ff;
    acmp2_strb_t wStrb_ff;
    logic bValid_ff;
    acmp2_resp_t bResp_ff;
    logic doWrite;
    logic wrMapped;

    assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awReady_ff <= 1'b1;
            awHeld_ff <= 1'b0;
            awAddr_ff <= 12'h000;
        end else if (awvalid && awReady_ff) begin
            awReady_ff <= 1'b0;
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end else if (bValid_ff && bready) begin
            awReady_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wReady_ff <= 1'b1;
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else if (wvalid && wReady_ff) begin
            wReady_ff <= 1'b0;
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end else if (bValid_ff && bready) begin
            wReady_ff <= 1'b1;
        end
    end

    assign wrMapped = (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_CTRL_IDX))
        || (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_STAT_IDX))
        || (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_CLR_IDX))
        || (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_EN_IDX));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bValid_ff <= 1'b0;
            bResp_ff <= `ACMP2_RESP_OKAY;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff <= wrMapped ? `ACMP2_RESP_OKAY : `ACMP2_RESP_SLVERR;
        end else if (bValid_ff && bready) begin
            bValid_ff <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data
    logic ctrlWr;
    logic irqClrWr;
    logic irqEnWr;

    assign ctrlWr = doWrite && wStrb_ff[0]
        && (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_CTRL_IDX));
    assign irqClrWr = doWrite && wStrb_ff[0]
        && (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_CLR_IDX));
    assign irqEnWr = doWrite && wStrb_ff[0]
        && (awAddr_ff == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_EN_IDX));

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic hys_ff;
    logic en_ff;
    logic pair_ff;
    logic neg_ff;
    logic oe_ff;

    localparam logic [7:0] CTRL_RST = `ACMP2_CTRL_RST;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hys_ff <= CTRL_RST[`ACMP2_HYS_BIT];
            en_ff <= CTRL_RST[`ACMP2_EN_BIT];
            pair_ff <= CTRL_RST[`ACMP2_PAIR_BIT];
            neg_ff <= CTRL_RST[`ACMP2_NEG_BIT];
            oe_ff <= CTRL_RST[`ACMP2_OE_BIT];
        end else if (ctrlWr) begin
            hys_ff <= wData_ff[`ACMP2_HYS_BIT];
            en_ff <= wData_ff[`ACMP2_EN_BIT];
            pair_ff <= wData_ff[`ACMP2_PAIR_BIT];
            neg_ff <= wData_ff[`ACMP2_NEG_BIT];
            oe_ff <= wData_ff[`ACMP2_OE_BIT];
        end
    end

    assign hysteresisEn = hys_ff;
    assign comparatorEn = en_ff;
    assign inputPairSel = pair_ff;
    assign negativeInputSel = neg_ff;

    // ----------------------------------------------------------------
    // Output pin, sampled state and change detection
    // ----------------------------------------------------------------
    logic pinOe_ff;
    logic syncOut;
    logic prevSync_ff;
    logic outState_ff;
    logic setChange;
    logic changeFlag;
    logic flagClrSw;

    // raw output passes straight through; enable is registered
    assign cmpPinOut = cmpRaw;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinOe_ff <= 1'b0;
        end else begin
            pinOe_ff <= oe_ff && en_ff;
        end
    end
    assign cmpPinOe = pinOe_ff;

    // two-stage retiming of the comparator output
    acmp2_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn(cmpRaw),
        .syncOut(syncOut)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prevSync_ff <= 1'b0;
        end else begin
            prevSync_ff <= syncOut;
        end
    end

    // read-only state, forced low while disabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outState_ff <= 1'b0;
        end else begin
            outState_ff <= en_ff && syncOut;
        end
    end

    // either edge sets the flag while running
    assign setChange = en_ff && (syncOut != prevSync_ff);
    // clear on zero write or while disabled
    assign flagClrSw = (ctrlWr && !wData_ff[`ACMP2_FLAG_BIT]) || !en_ff;

    acmp2_flag u_change (
        .mclk(mclk),
        .rst(rst),
        .setIn(setChange),
        .clrIn(flagClrSw),
        .flagOut(changeFlag)
    );

    // ----------------------------------------------------------------
    // Interrupt status, clear and enable
    // ----------------------------------------------------------------
    logic irqStat;
    logic irqEn_ff;
    logic irq_ff;

    acmp2_flag u_irq_stat (
        .mclk(mclk),
        .rst(rst),
        .setIn(setChange),
        .clrIn(irqClrWr && wData_ff[`ACMP2_IRQ_CHANGE_BIT]),
        .flagOut(irqStat)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqEn_ff <= `ACMP2_IRQ_EN_RST;
        end else if (irqEnWr) begin
            irqEn_ff <= wData_ff[`ACMP2_IRQ_CHANGE_BIT];
        end
    end

    // request held while an enabled event is pending
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irqStat && irqEn_ff;
        end
    end
    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // Bus slave: read channel
    // ----------------------------------------------------------------
    logic arReady_ff;
    logic rValid_ff;
    acmp2_data_t rData_ff;
    acmp2_resp_t rResp_ff;
    acmp2_data_t rdMux;
    logic rdHit;

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        if (araddr == `ACMP2_IDX_TO_ADDR(`ACMP2_CTRL_IDX)) begin
            rdMux[`ACMP2_HYS_BIT] = hys_ff;
            rdMux[`ACMP2_EN_BIT] = en_ff;
            rdMux[`ACMP2_PAIR_BIT] = pair_ff;
            rdMux[`ACMP2_NEG_BIT] = neg_ff;
            rdMux[`ACMP2_OE_BIT] = oe_ff;
            rdMux[`ACMP2_OUT_BIT] = outState_ff;
            rdMux[`ACMP2_FLAG_BIT] = changeFlag;
        end else if (araddr == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_STAT_IDX)) begin
            rdMux[`ACMP2_IRQ_CHANGE_BIT] = irqStat;
        end else if (araddr == `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_EN_IDX)) begin
            rdMux[`ACMP2_IRQ_CHANGE_BIT] = irqEn_ff;
        end else if (araddr != `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_CLR_IDX)) begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arReady_ff <= 1'b1;
            rValid_ff <= 1'b0;
            rData_ff <= 32'h0000_0000;
            rResp_ff <= `ACMP2_RESP_OKAY;
        end else if (arvalid && arReady_ff) begin
            arReady_ff <= 1'b0;
            rValid_ff <= 1'b1;
            rData_ff <= rdMux;
            rResp_ff <= rdHit ? `ACMP2_RESP_OKAY : `ACMP2_RESP_SLVERR;
        end else if (rValid_ff && rready) begin
            rValid_ff <= 1'b0;
            arReady_ff <= 1'b1;
        end
    end

    assign awready = awReady_ff;
    assign wready = wReady_ff;
    assign bvalid = bValid_ff;
    assign bresp = bResp_ff;
    assign arready = arReady_ff;
    assign rvalid = rValid_ff;
    assign rdata = rData_ff;
    assign rresp = rResp_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    hys_follow_a: assert property (ctrlWr |=> hysteresisEn == $past(wData_ff[6]))
        else $error("hysteresis enable does not follow write");
    en_follow_a: assert property (ctrlWr |=> comparatorEn == $past(wData_ff[5]))
        else $error("comparator enable does not follow write");
    pair_sel_a: assert property (!ctrlWr |=> $stable(inputPairSel))
        else $error("pair select changed without a write");
    neg_sel_a: assert property (ctrlWr |=> negativeInputSel == $past(wData_ff[3]))
        else $error("negative select does not follow write");
    pin_gate_a: assert property (!en_ff [*2] |-> !cmpPinOe)
        else $error("output pin enabled while comparator off");
    out_forced_a: assert property (!en_ff |=> !outState_ff)
        else $error("output state not zero while disabled");
    edge_sets_a: assert property ($past(en_ff) && $changed(prevSync_ff) |-> changeFlag)
        else $error("output change did not set flag");
    sync_change_a: assert property ($changed(syncOut) && en_ff |=> changeFlag)
        else $error("synchronised edge missed");
    irq_raise_a: assert property (changeFlag && irqEn_ff |-> ##[1:2] irq)
        else $error("interrupt not raised for set flag");
    disable_clr_a: assert property (!en_ff |=> !changeFlag)
        else $error("flag survives disabled comparator");
    set_wins_a: assert property (setChange && ctrlWr |=> changeFlag)
        else $error("hardware set lost to software clear");

    flag_cycle_c: cover property (changeFlag ##[1:20] !changeFlag);
    irq_seen_c: cover property ($rose(irq));
    read_done_c: cover property (rValid_ff && rready && rResp_ff == 2'h0);
endmodule
`default_nettype wire

// *** bench/acmp2_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acmp2_core_model #(
    parameter int VREF_MV = 1200, // Internal reference level
    parameter int HYS_MV = 20, // Hysteresis band width
    parameter int SETTLE_NS = 10000 // Output unstable after power-up
) (
    input wire logic comparatorEn, // Power-up control
    input wire logic hysteresisEn, // Hysteresis on
    input wire logic inputPairSel, // Input pair select
    input wire logic negativeInputSel, // Negative input select
    input wire logic [11:0] posAMv, // First pair positive pin, mV
    input wire logic [11:0] posBMv, // Second pair positive pin, mV
    input wire logic [11:0] refMv, // Reference pin, mV
    output logic cmpRaw // Raw comparator output
);
    int p;
    int n;
    int h;
    logic settling = 1'b0;
    // ------
    // Analog core
    // ------
    initial cmpRaw = 1'b0;
    always @(posedge comparatorEn) begin
        settling = 1'b1;
        #(SETTLE_NS) settling = 1'b0;
    end
    // Unpowered or settling output wanders, so nothing may be trusted from it
    always begin
        #70;
        if (!comparatorEn || settling) begin
            cmpRaw = ~cmpRaw;
        end else begin
            p = inputPairSel ? int'(posBMv) : int'(posAMv);
            n = negativeInputSel ? VREF_MV : int'(refMv);
            h = hysteresisEn ? HYS_MV / 2 : 0;
            cmpRaw = cmpRaw ? (p >= n - h) : (p > n + h);
        end
    end
endmodule
`default_nettype wire

// *** bench/analog_comparator_two_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acmp2_map.svh"
module analog_comparator_two_control_bench;
    import acmp2_pkg::*;
    localparam acmp2_addr_t CTRL = `ACMP2_IDX_TO_ADDR(`ACMP2_CTRL_IDX);
    localparam acmp2_addr_t STAT = `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_STAT_IDX);
    localparam acmp2_addr_t CLR = `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_CLR_IDX);
    localparam acmp2_addr_t ENA = `ACMP2_IDX_TO_ADDR(`ACMP2_IRQ_EN_IDX);
    localparam acmp2_addr_t BAD = 12'h100;
    localparam acmp2_resp_t OK = `ACMP2_RESP_OKAY;
    localparam acmp2_resp_t ERR = `ACMP2_RESP_SLVERR;
    logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cmpRaw, hysteresisEn, comparatorEn;
    logic inputPairSel, negativeInputSel, cmpPinOut, cmpPinOe, irq;
    acmp2_addr_t awaddr, araddr;
    acmp2_data_t wdata, rdata;
    acmp2_strb_t wstrb;
    acmp2_resp_t bresp, rresp;
    logic [11:0] posAMv, posBMv, refMv;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    acmp2_ctrl DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmpRaw(cmpRaw),
        .hysteresisEn(hysteresisEn), .comparatorEn(comparatorEn),
        .inputPairSel(inputPairSel), .negativeInputSel(negativeInputSel),
        .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe), .irq(irq));

    acmp2_core_model core (.comparatorEn(comparatorEn), .hysteresisEn(hysteresisEn),
        .inputPairSel(inputPairSel), .negativeInputSel(negativeInputSel),
        .posAMv(posAMv), .posBMv(posBMv), .refMv(refMv), .cmpRaw(cmpRaw));

    // ------
    // Checking and bus tasks
    // ------
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic note(input bit bad, input string what);
        n_tests++;
        if (bad) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic checkBit(input logic act, input logic exp, input string what);
        note(act !== exp, what);
    endtask
    task automatic checkData(input acmp2_data_t act, input acmp2_data_t exp);
        note(act !== exp, "read data");
    endtask
    task automatic checkResp(input acmp2_resp_t act, input acmp2_resp_t exp);
        note(act !== exp, "response code");
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input acmp2_addr_t a, input acmp2_data_t d, input acmp2_strb_t s,
        input acmp2_resp_t er);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        checkResp(bresp, er);
    endtask
    task automatic rd(input acmp2_addr_t a, input acmp2_data_t ed, input acmp2_resp_t er);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        checkData(rdata, ed);
        checkResp(rresp, er);
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // A hang ends the run as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end

    // ------
    // Test sequence
    // ------
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h0;
        posAMv = 12'd1000;
        posBMv = 12'd1300;
        refMv = 12'd1100;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(CTRL, 32'h0, OK);
        rd(ENA, 32'h0, OK);
        checkBit(irq, 1'b0, "irq after reset");
        $display("reset values done");
        wr(CTRL, 32'hDA, 4'hF, OK);
        checkBit(hysteresisEn, 1'b1, "hysteresis");
        checkBit(comparatorEn, 1'b0, "enable");
        checkBit(inputPairSel, 1'b1, "pair");
        checkBit(negativeInputSel, 1'b1, "negative input");
        rd(CTRL, 32'h58, OK);
        $display("field routing done");
        wr(CTRL, 32'h24, 4'hF, OK);
        checkBit(comparatorEn, 1'b1, "enable");
        checkBit(hysteresisEn, 1'b0, "hysteresis");
        wr(CTRL, 32'h24, 4'hF, OK);
        tick(110);
        wr(CTRL, 32'h24, 4'hF, OK);
        wr(CLR, 32'h1, 4'hF, OK);
        rd(CTRL, 32'h24, OK);
        rd(STAT, 32'h0, OK);
        checkBit(cmpPinOe, 1'b1, "pin enable");
        $display("enable done");
        @(posedge mclk);
        posAMv <= 12'd1200;
        tick(8);
        checkBit(cmpPinOut, 1'b1, "pin level");
        rd(CTRL, 32'h27, OK);
        rd(STAT, 32'h1, OK);
        checkBit(irq, 1'b0, "irq masked");
        wr(ENA, 32'h1, 4'hF, OK);
        tick(1);
        checkBit(irq, 1'b1, "irq enabled");
        wr(CTRL, 32'h24, 4'hF, OK);
        rd(CTRL, 32'h26, OK);
        checkBit(irq, 1'b1, "irq status sticky");
        wr(CLR, 32'h1, 4'hF, OK);
        tick(1);
        checkBit(irq, 1'b0, "irq cleared");
        rd(CLR, 32'h0, OK);
        @(posedge mclk);
        posAMv <= 12'd1000;
        tick(8);
        checkBit(cmpPinOut, cmpRaw, "pin path");
        rd(CTRL, 32'h25, OK);
        checkBit(irq, 1'b1, "irq on fall");
        wr(ENA, 32'h0, 4'hF, OK);
        tick(1);
        checkBit(irq, 1'b0, "irq masked again");
        wr(CLR, 32'h1, 4'hF, OK);
        $display("change detection done");
        wr(CTRL, 32'h34, 4'hF, OK);
        tick(8);
        rd(CTRL, 32'h37, OK);
        wr(CTRL, 32'h10, 4'hF, OK);
        tick(1);
        checkBit(cmpPinOe, 1'b0, "pin enable off");
        tick(20);
        rd(CTRL, 32'h10, OK);
        $display("pair and disable done");
        wr(BAD, 32'hFF, 4'hF, ERR);
        rd(BAD, 32'h0, ERR);
        wr(CTRL, 32'h24, 4'h0, OK);
        rd(CTRL, 32'h10, OK);
        $display("refusals done");
        results();
    end
endmodule
`default_nettype wire
